// File: src/fwsr_pkg.sv
// shared constants, types and status layout of the flash write status logic
package fwsr_pkg;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned PROT_PGM_NS   = 2000;
  localparam int unsigned PROT_ERS_US   = 100;
  localparam int unsigned ERASE_WIN_US  = 50;
  localparam int unsigned PGM_MAX_US    = 300;
  localparam longint     ERASE_MAX_MS   = 15000;
  localparam logic [31:0] PROT_PGM_CYC  = 32'(PROT_PGM_NS * CLK_MHZ / 1000);
  localparam logic [31:0] PROT_ERS_CYC  = 32'(PROT_ERS_US * CLK_MHZ);
  localparam logic [31:0] ERASE_WIN_CYC = 32'(ERASE_WIN_US * CLK_MHZ);
  localparam logic [31:0] PGM_MAX_CYC   = 32'(PGM_MAX_US * CLK_MHZ);
  localparam logic [31:0] ERASE_MAX_CYC = 32'(ERASE_MAX_MS * 64'd1000 * CLK_MHZ);
  localparam int unsigned ADDR_W_DEF    = 19;
  localparam int unsigned SBITS_DEF     = 3;
  localparam logic [18:0] PROT_ADDR     = 19'h03FFF;
  localparam int unsigned PROT_BIT      = 7;
  localparam logic [7:0] CMD_PROGRAM    = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SET  = 8'h80;
  localparam logic [7:0] CMD_SECTOR     = 8'h30;
  localparam logic [7:0] CMD_SUSPEND    = 8'hB0;
  localparam logic [7:0] CMD_RESUME     = 8'h30;
  localparam logic [7:0] CMD_RESET      = 8'hF0;
  localparam logic [7:0] RD_RESET       = 8'h00;

  // status byte as seen on the data bus during a status read
  typedef struct packed {
    logic dataPoll;
    logic toggleOne;
    logic timeoutFlag;
    logic rsv4;
    logic eraseTimer;
    logic toggleTwo;
    logic rsv1;
    logic rsv0;
  } fwsr_status_s;

  typedef enum logic [3:0] {
    ST_READ, ST_PGM_SET, ST_ERS_SET, ST_WIN, ST_ERASE,
    ST_SUSP, ST_PGM, ST_PROT, ST_TOUT
  } fwsr_state_e;
endpackage

// File: src/fwsr_flash_status.sv
// program and erase sequencer with toggle, timeout and timer status reporting
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
// Function
// RL1: erase of only protected sectors toggles briefly then returns to array reads
// RL2: mixed erase selection erases only the unprotected sectors
// RL3: toggle bit one runs during erase and freezes in suspend
// RL4: program into protected sector toggles about 2 us then returns
// RL5: program during suspend toggles bit one until program completes
// RL6: toggle bit two flips on reads of sectors selected for erase
// RL7: host reads status twice; equal toggles mean done
// RL8: host rechecks toggling after timeout flag; still toggling means reset
// RL9: host restarts toggle detection after leaving polling
// RL10: timeout flag rises when pulse-count limit is exceeded
// RL11: in timeout only status reads work, commands are dropped
// RL12: after timeout a reset command is needed, then good sectors work
// RL13: programming a non-blank location never raises timeout
// RL14: erase window starts after first sector command, timer flag low inside
// RL15: status is valid right after the first sector erase command
// RL16: timer flag high means erasing; further commands ignored
// RL17: timer flag low lets more sector commands join the erase
// RL18: host checks timer flag before and after each added sector
// RL19: protection bit 7 one allows debugger download, zero blocks it
// RL20: protection bit never gates processor instruction fetch
// RL21: host writes the seven low protection bits as zero
// RL22: toggle bit one inverts on every read while an operation runs
// RL23: one read gives all status bits with reserved bits zero
module fwsr_flash_status
  import fwsr_pkg::*;
#(
  parameter int unsigned ADDR_W  = fwsr_pkg::ADDR_W_DEF,
  parameter int unsigned SBITS   = fwsr_pkg::SBITS_DEF,
  parameter logic [31:0] WIN_CYC = fwsr_pkg::ERASE_WIN_CYC,
  parameter logic [31:0] PE_CYC  = fwsr_pkg::PROT_ERS_CYC,
  parameter logic [31:0] PGM_LIM = fwsr_pkg::PGM_MAX_CYC,
  parameter logic [31:0] ERS_LIM = fwsr_pkg::ERASE_MAX_CYC
)(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic [ADDR_W-1:0]     busAddr,
  input  wire logic [7:0]            busWrData,
  input  wire logic                  busWrite,
  input  wire logic                  busRead,
  output logic      [7:0]            busRdData,
  input  wire logic [7:0]            arrayData,
  input  wire logic [7:0]            protByte,
  input  wire logic [(1<<SBITS)-1:0] sectorProt,
  input  wire logic                  coreDone,
  output logic                       pgmRun,
  output logic                       eraseRun,
  output logic      [ADDR_W-1:0]     pgmAddr,
  output logic      [7:0]            pgmData,
  output logic      [(1<<SBITS)-1:0] eraseMask,
  input  wire logic                  dbgRead,
  output logic      [7:0]            dbgRdData,
  output logic                       dbgBlocked
);
  import fwsr_pkg::*;

  localparam int unsigned NSEC = 1 << SBITS;

  fwsr_state_e      state;
  logic [31:0]      cnt;
  logic [31:0]      protLim;
  logic             protIsPgm;
  logic             inSusp;
  logic             nonBlank;
  logic [NSEC-1:0]  selMask;
  logic             toggleOne;
  logic             toggleTwo;
  logic             protOff;
  logic [SBITS-1:0] rdSec;
  logic             busy;
  logic             pgmKind;
  logic             eraseKind;
  logic             statusSel;
  logic             etBit;
  fwsr_status_s     status;

  // sector number from the top address bits
  function automatic logic [SBITS-1:0] sectorOf(input logic [ADDR_W-1:0] a);
    sectorOf = a[ADDR_W-1 -: SBITS];
  endfunction

  // one-hot bit for a sector
  function automatic logic [NSEC-1:0] secBit(input logic [ADDR_W-1:0] a);
    secBit = NSEC'(1) << sectorOf(a);
  endfunction

  // decode of the current operation kind
  assign rdSec     = sectorOf(busAddr);
  assign eraseKind = (state == ST_WIN) | (state == ST_ERASE) | (state == ST_SUSP)
                   | ((state == ST_PROT) & ~protIsPgm) | ((state == ST_TOUT) & |selMask);
  assign pgmKind   = (state == ST_PGM) | ((state == ST_PROT) & protIsPgm)
                   | ((state == ST_TOUT) & ~|selMask);
  assign busy      = (state == ST_WIN) | (state == ST_ERASE) | (state == ST_PGM)
                   | (state == ST_PROT) | (state == ST_TOUT);
  assign etBit     = (state == ST_ERASE) | ((state == ST_TOUT) & |selMask); // RL14 RL16
  // status reads: busy, or suspended erase at a selected sector
  assign statusSel = busy | ((state == ST_SUSP) & selMask[rdSec]); // RL15

  // status byte, reserved bits fixed at zero
  always_comb
  begin
    status             = '0; // RL23
    status.dataPoll    = pgmKind ? ~pgmData[7] : (state == ST_SUSP);
    status.toggleOne   = toggleOne;
    status.timeoutFlag = (state == ST_TOUT); // RL10
    status.eraseTimer  = etBit;
    status.toggleTwo   = toggleTwo;
  end

  // command decode, operation timing and drive to the array macro
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state     <= ST_READ;
      cnt       <= '0;
      protLim   <= '0;
      protIsPgm <= 1'b0;
      inSusp    <= 1'b0;
      nonBlank  <= 1'b0;
      selMask   <= '0;
      pgmRun    <= 1'b0;
      eraseRun  <= 1'b0;
      pgmAddr   <= '0;
      pgmData   <= '0;
      eraseMask <= '0;
    end
    else
    begin
      case (state)
        ST_READ:
        begin
          if (busWrite && busWrData == CMD_PROGRAM)
            state <= ST_PGM_SET;
          else if (busWrite && busWrData == CMD_ERASE_SET)
            state <= ST_ERS_SET;
        end
        ST_PGM_SET:
        begin
          if (busWrite)
          begin
            pgmAddr  <= busAddr;
            pgmData  <= busWrData;
            nonBlank <= |(busWrData & ~arrayData); // RL13
            cnt      <= '0;
            if (sectorProt[sectorOf(busAddr)])
            begin
              state     <= ST_PROT; // RL4
              protLim   <= PROT_PGM_CYC;
              protIsPgm <= 1'b1;
            end
            else
            begin
              state  <= ST_PGM; // RL5
              pgmRun <= 1'b1;
            end
          end
        end
        ST_ERS_SET:
        begin
          if (busWrite && busWrData == CMD_SECTOR)
          begin
            selMask <= secBit(busAddr);
            cnt     <= '0;
            state   <= ST_WIN; // RL14
          end
          else if (busWrite)
            state <= ST_READ;
        end
        ST_WIN:
        begin
          cnt <= cnt + 32'h1;
          if (busWrite && busWrData == CMD_SECTOR)
          begin
            selMask <= selMask | secBit(busAddr); // RL17
            cnt     <= '0;
          end
          else if (busWrite && busWrData == CMD_SUSPEND)
            state <= ST_SUSP;
          else if (cnt >= WIN_CYC - 32'h1)
          begin
            cnt <= '0;
            if ((selMask & ~sectorProt) == '0)
            begin
              state     <= ST_PROT; // RL1
              protLim   <= PE_CYC;
              protIsPgm <= 1'b0;
            end
            else
            begin
              state     <= ST_ERASE;
              eraseMask <= selMask & ~sectorProt; // RL2
              eraseRun  <= 1'b1;
            end
          end
        end
        ST_ERASE:
        begin
          cnt <= cnt + 32'h1; // RL16
          if (coreDone)
          begin
            state    <= ST_READ;
            eraseRun <= 1'b0;
            selMask  <= '0;
          end
          else if (cnt >= ERS_LIM)
          begin
            state    <= ST_TOUT; // RL10
            eraseRun <= 1'b0;
          end
          else if (busWrite && busWrData == CMD_SUSPEND)
          begin
            state    <= ST_SUSP; // RL3
            eraseRun <= 1'b0;
          end
        end
        ST_SUSP:
        begin
          if (busWrite && busWrData == CMD_PROGRAM)
          begin
            state  <= ST_PGM_SET;
            inSusp <= 1'b1;
          end
          else if (busWrite && busWrData == CMD_RESUME)
          begin
            cnt       <= '0;
            state     <= ST_ERASE;
            eraseMask <= selMask & ~sectorProt; // RL2
            eraseRun  <= 1'b1;
          end
        end
        ST_PGM:
        begin
          cnt <= cnt + 32'h1;
          if (coreDone)
          begin
            state  <= inSusp ? ST_SUSP : ST_READ; // RL5
            inSusp <= 1'b0;
            pgmRun <= 1'b0;
          end
          else if (cnt >= PGM_LIM && !nonBlank)
          begin
            state  <= ST_TOUT; // RL10 RL13
            pgmRun <= 1'b0;
          end
        end
        ST_PROT:
        begin
          cnt <= cnt + 32'h1;
          if (cnt >= protLim - 32'h1)
          begin
            state   <= inSusp ? ST_SUSP : ST_READ; // RL1 RL4
            inSusp  <= 1'b0;
            selMask <= protIsPgm ? selMask : '0;
          end
        end
        ST_TOUT:
        begin
          if (busWrite && busWrData == CMD_RESET)
          begin
            state   <= ST_READ; // RL11 RL12
            selMask <= '0;
            inSusp  <= 1'b0;
          end
        end
        default:
          state <= ST_READ;
      endcase
    end
  end

  // toggle bit one flips on each status read while busy, toggle bit two on status reads of a sector selected for erase while the current operation is an erase
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      toggleOne <= 1'b0;
      toggleTwo <= 1'b0;
    end
    else if (busRead && statusSel)
    begin
      if (busy)
        toggleOne <= ~toggleOne; // RL22 RL3
      if (eraseKind && selMask[rdSec])
        toggleTwo <= ~toggleTwo; // RL6
    end
  end

  // processor read path: status or array, never gated by protection
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      busRdData <= RD_RESET;
    else if (busRead)
      busRdData <= statusSel ? status : arrayData; // RL20 RL23
    else
      busRdData <= RD_RESET;
  end

  // debugger download gated by the stored protection bit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      protOff    <= 1'b0;
      dbgBlocked <= 1'b1;
      dbgRdData  <= RD_RESET;
    end
    else
    begin
      protOff    <= protByte[PROT_BIT]; // RL19
      dbgBlocked <= ~protOff;
      if (dbgRead && protOff)
        dbgRdData <= arrayData; // RL19
      else
        dbgRdData <= RD_RESET;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence protPgmEnter;
    (state == ST_PGM_SET) && busWrite && sectorProt[sectorOf(busAddr)];
  endsequence

  sequence protPgmHold;
    (state == ST_PROT)[*8];
  endsequence

  tgl_one_busy_a: assert property (busRead && statusSel && busy |=> toggleOne != $past(toggleOne)) // RL22
    else $error("toggle bit one did not flip while busy");
  tgl_susp_hold_a: assert property ((state == ST_SUSP) && $past(state == ST_SUSP) |-> $stable(toggleOne)) // RL3
    else $error("toggle bit one moved in suspend");
  prot_pgm_a: assert property (protPgmEnter |=> protPgmHold ##1 (cnt >= 32'h8)) // RL4
    else $error("protected program did not toggle");
  prot_lim_a: assert property ((state == ST_PROT) |-> cnt < protLim) // RL4
    else $error("protected toggle overran");
  erase_mask_a: assert property ($rose(eraseRun) |-> (eraseMask & sectorProt) == '0) // RL2
    else $error("protected sector erased");
  prot_noerase_a: assert property ((state == ST_PROT) |-> !eraseRun && !pgmRun) // RL1
    else $error("array driven during protected toggle");
  tout_hold_a: assert property ((state == ST_TOUT) && !(busWrite && busWrData == CMD_RESET)
                                |=> (state == ST_TOUT) && !pgmRun && !eraseRun) // RL11
    else $error("timeout left without reset");
  tout_reset_a: assert property ((state == ST_TOUT) && busWrite && busWrData == CMD_RESET
                                 |=> (state == ST_READ) ##1 !status.timeoutFlag) // RL12
    else $error("reset did not clear timeout");
  win_timer_a: assert property ((state == ST_WIN) |-> !status.eraseTimer && busy) // RL14
    else $error("timer flag high in window");
  erase_ign_a: assert property ((state == ST_ERASE) && busWrite && busWrData != CMD_SUSPEND
                                |=> state inside {ST_ERASE, ST_READ, ST_TOUT}) // RL16
    else $error("command taken while erasing");
  win_add_a: assert property ((state == ST_WIN) && busWrite && busWrData == CMD_SECTOR
                              |=> selMask[$past(rdSec)] && cnt == '0) // RL17
    else $error("added sector not taken");
  nonblank_a: assert property ((state == ST_PGM) && nonBlank |=> state != ST_TOUT) // RL13
    else $error("timeout on non-blank program");
  dbg_block_a: assert property (dbgRead && !protOff |=> dbgRdData == RD_RESET) // RL19
    else $error("debugger read not blocked");
endmodule

// File: dv/fwsr_array_model.sv
// flash array model: byte store that answers program and erase runs
`timescale 1ns/10ps
module fwsr_array_model
  import fwsr_pkg::*;
#(
  parameter int unsigned DONE_CYC = 30
)(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [18:0] busAddr,
  input  wire logic        pgmRun,
  input  wire logic        eraseRun,
  input  wire logic [18:0] pgmAddr,
  input  wire logic [7:0]  pgmData,
  input  wire logic [7:0]  eraseMask,
  input  wire logic        stall,
  output logic             coreDone,
  output logic [7:0]       arrayData
);
  logic [7:0]  mem [128];
  logic [31:0] cnt;
  // byte at the bus address, sixteen bytes kept per sector
  assign arrayData = mem[{busAddr[18:16], busAddr[3:0]}];
  // busy cycles counted; stall holds the count so a run can overstay its limit
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt      <= '0;
      coreDone <= 1'h0;
      for (int i = 0; i < 128; i++)
        mem[i] <= 8'hFF;
    end
    else
    begin
      coreDone <= 1'h0;
      if (!(pgmRun || eraseRun))
        cnt <= '0;
      else if (!stall)
        cnt <= cnt + 32'h1;
      if ((pgmRun || eraseRun) && !stall && cnt == DONE_CYC)
      begin
        coreDone <= 1'h1;
        if (pgmRun)
          mem[{pgmAddr[18:16], pgmAddr[3:0]}] <= mem[{pgmAddr[18:16], pgmAddr[3:0]}] & pgmData;
        else
          for (int k = 0; k < 128; k++)
            if (eraseMask[k >> 4])
              mem[k] <= 8'hFF;
      end
    end
  end
endmodule

// File: dv/fwsr_flash_status_tb.sv
// self-checking bench of the flash write status logic
`timescale 1ns/10ps
module fwsr_flash_status_tb;
  import fwsr_pkg::*;
  localparam logic [18:0] ADR_A = 19'h10005;
  localparam logic [18:0] ADR_B = 19'h10006;
  localparam logic [18:0] ADR_P = 19'h20005;
  localparam logic [18:0] ADR_C = 19'h30005;
  localparam logic [18:0] ADR_D = 19'h40005;
  logic        clk_sys = 1'h0, rst_b = 1'h0, busWrite = 1'h0, busRead = 1'h0;
  logic        dbgRead = 1'h0, stall = 1'h0, coreDone, pgmRun, eraseRun, dbgBlocked;
  logic [18:0] busAddr = '0, pgmAddr;
  logic [7:0]  busWrData = '0, protByte = 8'h80, sectorProt = 8'h04;
  logic [7:0]  busRdData, arrayData, dbgRdData, pgmData, eraseMask;
  int          nErrors = 0, samplesChecked = 0;

  fwsr_flash_status #(.WIN_CYC(32'h14), .PE_CYC(32'h14), .PGM_LIM(32'h32), .ERS_LIM(32'h64))
  fwsr_flash_status_i (.clk_sys(clk_sys), .rst_b(rst_b), .busAddr(busAddr),
    .busWrData(busWrData), .busWrite(busWrite), .busRead(busRead), .busRdData(busRdData),
    .arrayData(arrayData), .protByte(protByte), .sectorProt(sectorProt),
    .coreDone(coreDone), .pgmRun(pgmRun), .eraseRun(eraseRun), .pgmAddr(pgmAddr),
    .pgmData(pgmData), .eraseMask(eraseMask), .dbgRead(dbgRead), .dbgRdData(dbgRdData),
    .dbgBlocked(dbgBlocked));
  fwsr_array_model fwsr_array_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .busAddr(busAddr),
    .pgmRun(pgmRun), .eraseRun(eraseRun), .pgmAddr(pgmAddr), .pgmData(pgmData),
    .eraseMask(eraseMask), .stall(stall), .coreDone(coreDone), .arrayData(arrayData));

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  // verdict and end of run
  task automatic giveVerdict();
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busAddr   <= a;
    busWrData <= d;
    busWrite  <= 1'h1;
    @(posedge clk_sys);
    busWrite  <= 1'h0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [18:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busRead <= 1'h1;
    @(posedge clk_sys);
    busRead <= 1'h0;
    #1 d = busRdData;
  endtask
  // two reads in a row
  task automatic rd2(input logic [18:0] a, output logic [7:0] s1, output logic [7:0] s2);
    rd(a, s1);
    rd(a, s2);
  endtask
  // toggle detection from its first step; done once bit six holds still
  task automatic poll(input logic [18:0] a);
    logic [7:0] s1, s2;
    for (int i = 0; i < 200; i++)
    begin
      rd2(a, s1, s2);
      if (s1[6] == s2[6])
        return;
    end
    nErrors++;
    giveVerdict();
  endtask
  // bounded wait for the erase run level
  task automatic waitErase(input logic lvl);
    for (int i = 0; i < 100; i++)
    begin
      @(posedge clk_sys);
      #1;
      if (eraseRun === lvl)
        return;
    end
    nErrors++;
    giveVerdict();
  endtask
  // plain program with status snapshot
  task automatic scnProgram();
    logic [7:0] s1, s2;
    wr(19'h0, CMD_PROGRAM);
    wr(ADR_A, 8'h0F);
    rd2(ADR_A, s1, s2);
    chk(s1[6] ^ s2[6], 1'h1);
    chk({s1[7], s1 & 8'h13}, 9'h100);
    chk({pgmRun, pgmAddr, pgmData}, {1'h1, ADR_A, 8'h0F});
    poll(ADR_A);
    rd(ADR_A, s1);
    chk(s1, 8'h0F);
  endtask
  // debugger download gated by the protection bit, core reads not
  task automatic scnDebug();
    logic [7:0] d;
    chk(dbgBlocked, 1'h0);
    @(posedge clk_sys);
    busAddr <= ADR_A;
    dbgRead <= 1'h1;
    @(posedge clk_sys);
    dbgRead  <= 1'h0;
    protByte <= 8'h00;
    #1 chk(dbgRdData, 8'h0F);
    repeat (3) @(posedge clk_sys);
    dbgRead <= 1'h1;
    @(posedge clk_sys);
    dbgRead <= 1'h0;
    #1 chk({dbgBlocked, dbgRdData}, 9'h100);
    rd(ADR_A, d);
    chk(d, 8'h0F);
  endtask
  // program into a protected sector
  task automatic scnProtPgm();
    logic [7:0] s1, s2;
    wr(19'h0, CMD_PROGRAM);
    wr(ADR_P, 8'h00);
    rd2(ADR_P, s1, s2);
    chk({s1[6] ^ s2[6], pgmRun}, 2'h2);
    repeat (500) @(posedge clk_sys);
    rd(ADR_P, s1);
    chk(s1, 8'hFF);
  endtask
  // non-blank program, then a real timeout and its recovery
  task automatic scnTimeout();
    logic [7:0] s1, s2;
    stall <= 1'h1;
    wr(19'h0, CMD_PROGRAM);
    wr(ADR_A, 8'hF0);
    repeat (80) @(posedge clk_sys);
    rd(ADR_A, s1);
    chk(s1[5], 1'h0);
    stall <= 1'h0;
    poll(ADR_A);
    rd(ADR_A, s1);
    chk(s1, 8'h00);
    stall <= 1'h1;
    wr(19'h0, CMD_PROGRAM);
    wr(ADR_B, 8'h55);
    repeat (80) @(posedge clk_sys);
    rd2(ADR_B, s1, s2);
    chk({s1[5], s1[6] ^ s2[6]}, 2'h3);
    wr(19'h0, CMD_ERASE_SET);
    rd(ADR_B, s1);
    chk(s1[5], 1'h1);
    wr(19'h0, CMD_RESET);
    rd(ADR_B, s1);
    chk(s1, 8'hFF);
    stall <= 1'h0;
    wr(19'h0, CMD_PROGRAM);
    wr(ADR_B, 8'h55);
    poll(ADR_B);
    rd(ADR_B, s1);
    chk(s1, 8'h55);
  endtask
  // erase of mixed sectors with added sectors, suspend and resume
  task automatic scnErase();
    logic [7:0] s1, s2;
    stall <= 1'h1;
    wr(19'h0, CMD_ERASE_SET);
    wr(ADR_A, CMD_SECTOR);
    rd2(ADR_A, s1, s2);
    chk({s1[6] ^ s2[6], s2[3]}, 2'h2);
    wr(ADR_P, CMD_SECTOR);
    wr(ADR_C, CMD_SECTOR);
    rd(ADR_A, s1);
    chk(s1[3], 1'h0);
    waitErase(1'h1);
    chk(eraseMask, 8'h0A);
    rd2(ADR_A, s1, s2);
    chk({s1[3], s1[2] ^ s2[2]}, 2'h3);
    rd2(ADR_D, s1, s2);
    chk(s1[2] ^ s2[2], 1'h0);
    wr(ADR_D, CMD_SECTOR);
    rd(ADR_A, s1);
    chk(eraseMask, 8'h0A);
    wr(19'h0, CMD_SUSPEND);
    repeat (4) @(posedge clk_sys);
    rd2(ADR_A, s1, s2);
    chk({s1[6] ^ s2[6], s1[2] ^ s2[2], s1[7]}, 3'h3);
    stall <= 1'h0;
    wr(19'h0, CMD_PROGRAM);
    wr(ADR_D, 8'h3C);
    rd2(ADR_D, s1, s2);
    chk({s1[6] ^ s2[6], pgmRun}, 2'h3);
    poll(ADR_D);
    rd2(ADR_A, s1, s2);
    chk({s1[6] ^ s2[6], s1[7]}, 2'h1);
    rd(ADR_D, s1);
    chk(s1, 8'h3C);
    wr(ADR_A, CMD_RESUME);
    rd2(ADR_A, s1, s2);
    chk(s1[6] ^ s2[6], 1'h1);
    poll(ADR_A);
    rd(ADR_A, s1);
    chk(s1, 8'hFF);
  endtask
  // erase that selects only a protected sector
  task automatic scnAllProt();
    logic [7:0] s1, s2;
    wr(19'h0, CMD_ERASE_SET);
    wr(ADR_P, CMD_SECTOR);
    rd2(ADR_P, s1, s2);
    chk(s1[6] ^ s2[6], 1'h1);
    repeat (60) @(posedge clk_sys);
    rd(ADR_P, s1);
    chk({eraseRun, s1}, 9'h0FF);
  endtask
  // erase that overruns its pulse limit, then reset back to array reads
  task automatic scnEraseTout();
    logic [7:0] s1, s2;
    stall <= 1'h1;
    wr(19'h0, CMD_ERASE_SET);
    wr(ADR_C, CMD_SECTOR);
    repeat (140) @(posedge clk_sys);
    rd2(ADR_C, s1, s2);
    chk({s1[5], s1[3], s1[2] ^ s2[2], eraseRun}, 4'hE);
    wr(19'h0, CMD_RESET);
    rd(ADR_C, s1);
    chk(s1, 8'hFF);
    stall <= 1'h0;
  endtask
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys);
    chk({busRdData, dbgBlocked, pgmRun, eraseRun}, 11'h004);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk_sys);
    scnProgram();
    scnDebug();
    scnProtPgm();
    scnTimeout();
    scnErase();
    scnAllProt();
    scnEraseTout();
    giveVerdict();
  end
  // hang guard
  initial
  begin
    #100000;
    nErrors++;
    giveVerdict();
  end
endmodule
